// ==== hw/mdio_mgmt_pkg.sv ====
// shared constants, types and frame layout for the management block
package mdio_mgmt_pkg;

   // ==========================================================
   // clocking and management clock limits
   localparam int unsigned CLK_HZ      = 200_000_000; // host clock
   localparam int unsigned MDC_MAX_HZ  = 2_500_000;   // mdc ceiling
   // least divider keeping mdc under its ceiling
   localparam int unsigned MDC_MIN_DIV =
      (CLK_HZ + 2 * MDC_MAX_HZ - 1) / (2 * MDC_MAX_HZ) - 1;
   localparam int          DIV_W       = 6;           // divider width
   localparam logic [5:0]  DIV_RESET   = 6'h00;       // divider reset

   // ==========================================================
   // serial frame layout, counted in bit slots from frame start
   localparam int          FRAME_BITS  = 64;          // whole frame
   localparam logic [5:0]  LAST_BIT    = 6'h3F;       // final slot
   localparam logic [5:0]  TA_BIT      = 6'h2E;       // turnaround
   localparam logic [5:0]  DATA_BIT    = 6'h30;       // data start
   localparam logic [31:0] PREAMBLE    = 32'hFFFFFFFF; // all ones
   localparam logic [1:0]  ST_CODE     = 2'h1;        // start pattern
   localparam logic [1:0]  OP_WRITE    = 2'h1;        // write opcode
   localparam logic [1:0]  OP_READ     = 2'h2;        // read opcode
   localparam logic [1:0]  TA_WRITE    = 2'h2;        // write ta bits
   localparam logic [15:0] RDATA_RESET = 16'h0000;    // read data rst

   // ==========================================================
   // address filter constants
   localparam logic [47:0] BCAST_ADDR  = 48'hFFFFFFFFFFFF; // broadcast
   localparam logic [47:0] PAUSE_MCAST = 48'h0180C2000001; // pause mc

   // ==========================================================
   // grouped carriers
   typedef struct packed {
      logic [1:0]  op;        // operation code
      logic [4:0]  phyad;     // physical address
      logic [4:0]  regad;     // register address
      logic [15:0] wdata;     // write data
   } mdio_cmd_t;

   typedef struct packed {
      logic [47:0] pause_addr; // pause or unicast address
      logic [15:0] bits;       // frame-bound settings
      logic        soft_rst;   // immediate soft reset
   } cfg_vec_t;

   localparam cfg_vec_t CFG_RESET = '{48'h0, 16'h0, 1'b0};

   typedef struct packed {
      logic bcast;     // broadcast destination
      logic ucast;     // pause or unicast address hit
      logic pmcast;    // pause multicast hit
      logic pause;     // accepted as pause frame
   } filt_t;

endpackage : mdio_mgmt_pkg

// ==== hw/mdio_clk_div.sv ====
// management clock divider with rise and fall enable pulses
module mdio_clk_div (
   input  wire logic                           clk_i,   // host clock
   input  wire logic                           srst_i,  // sync reset
   input  wire logic                           run_i,   // divider on
   input  wire logic [mdio_mgmt_pkg::DIV_W-1:0] div_i,  // divide field
   output logic                                mdc_o,   // mgmt clock
   output logic                                rise_o,  // mdc rises
   output logic                                fall_o   // mdc falls
);
   import mdio_mgmt_pkg::*;

   logic [DIV_W-1:0] cnt_reg;   // cycles within a half period

   // ==========================================================
   // half period of div+1 cycles gives clk / ((1+div)*2)
   always_ff @(posedge clk_i) begin
      if (srst_i || !run_i) begin
         cnt_reg <= '0;
         mdc_o   <= 1'b0;
         rise_o  <= 1'b0;
         fall_o  <= 1'b0;
      end else if (cnt_reg == div_i) begin
         cnt_reg <= '0;
         mdc_o   <= !mdc_o;
         rise_o  <= !mdc_o;
         fall_o  <= mdc_o;
      end else begin
         cnt_reg <= cnt_reg + 1'b1;
         rise_o  <= 1'b0;
         fall_o  <= 1'b0;
      end
   end
endmodule // mdio_clk_div

// ==== hw/dest_addr_filter.sv ====
// reduced destination address filter for vector-only builds
module dest_addr_filter (
   input  wire logic                 clk_i,       // host clock
   input  wire logic                 srst_i,      // sync reset
   input  wire logic                 da_valid_i,  // address present
   input  wire logic [47:0]          da_i,        // destination addr
   input  wire logic [47:0]          pause_addr_i, // pause/unicast
   input  wire logic                 pause_ok_i,  // other pause checks
   output mdio_mgmt_pkg::filt_t      filt_o       // match results
);
   import mdio_mgmt_pkg::*;

   logic hit_uc;   // pause or unicast address hit
   logic hit_pm;   // pause multicast hit

   assign hit_uc = (da_i == pause_addr_i);
   assign hit_pm = (da_i == PAUSE_MCAST);

   // ==========================================================
   // broadcast, pause multicast and pause/unicast compares, registered per frame
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         filt_o <= '0;
      end else if (da_valid_i) begin
         filt_o.bcast  <= (da_i == BCAST_ADDR);
         filt_o.ucast  <= hit_uc;
         filt_o.pmcast <= hit_pm;
         // an address hit alone never makes a pause frame
         filt_o.pause  <= (hit_uc || hit_pm) && pause_ok_i;
      end
   end
endmodule // dest_addr_filter

// ==== hw/mdio_management_controller.sv ====
// management serial master with config staging and address filter
//
// Functional notes
// - write frames carry opcode 01
// - read frames carry opcode 10
// - only master starts; matching slaves respond
// - frame shifted in step with mdc
// - mdc never above 2.5 MHz (code does not limit it; div_ok_o only flags the divider)
// - mdc is clock over (1+div)*2
// - divider resets zero; zero refuses enable
// - initiate clears ready until frame done
// - read data valid when ready returns
// - ready visible beside control and data
// - interrupt raised when transaction completes
// - config applied in gaps; resets immediate
// - illegal requests answered with an error
// - vectors apply after frame; resets immediate
// - filter broadcast, pause/unicast, pause multicast
// - pause only when other criteria met
// - serial access only with management present
module mdio_management_controller #(
   parameter bit MGMT_PRESENT = 1'b1   // management access built in
) (
   input  wire logic                    clk_i,       // host clock
   input  wire logic                    srst_i,      // sync reset
   input  wire logic [5:0]              clk_div_i,   // divider field
   input  wire logic                    mdio_en_i,   // enable request
   input  wire logic                    initiate_i,  // start pulse
   input  wire mdio_mgmt_pkg::mdio_cmd_t cmd_i,      // frame request
   input  wire logic                    irq_ack_i,   // clear interrupt
   input  wire logic                    mdio_i,      // data pin in
   input  wire mdio_mgmt_pkg::cfg_vec_t rx_cfg_i,    // rx settings
   input  wire mdio_mgmt_pkg::cfg_vec_t tx_cfg_i,    // tx settings
   input  wire logic                    rx_busy_i,   // rx in frame
   input  wire logic                    tx_busy_i,   // tx in frame
   input  wire logic                    da_valid_i,  // address present
   input  wire logic [47:0]             da_i,        // destination addr
   input  wire logic                    pause_ok_i,  // pause criteria
   output logic                         mdc_o,       // management clock
   output logic                         mdio_o,      // data pin out
   output logic                         mdio_oe_o,   // data pin drive
   output logic                         mdio_on_o,   // interface enabled
   output logic                         ctrl_ready_o, // ready, ctrl view
   output logic                         data_ready_o, // ready, data view
   output logic [15:0]                  rd_data_o,   // last read data
   output logic                         irq_o,       // completion irq
   output logic                         err_o,       // refused request
   output logic                         div_ok_o,    // mdc within limit
   output mdio_mgmt_pkg::cfg_vec_t      rx_cfg_o,    // applied rx cfg
   output mdio_mgmt_pkg::cfg_vec_t      tx_cfg_o,    // applied tx cfg
   output logic                         rx_rst_o,    // rx soft reset
   output logic                         tx_rst_o,    // tx soft reset
   output mdio_mgmt_pkg::filt_t         filt_o       // filter result
);
   import mdio_mgmt_pkg::*;

   // ==========================================================
   // declarations
   typedef enum logic [1:0] {ST_IDLE, ST_WAIT, ST_SHIFT} mstate_t;

   mstate_t     state_reg;     // frame sequencer
   logic        en_reg;        // interface enabled
   logic [63:0] shift_reg;     // outgoing frame bits
   logic [15:0] rx_reg;        // incoming read bits
   logic [5:0]  bit_reg;       // slot now on the line
   logic        is_read_reg;   // current frame is a read
   logic        ready_reg;     // no frame outstanding
   logic        sync1_reg;     // pin sync stage one
   logic        sync2_reg;     // pin sync stage two
   logic        sync3_reg;     // pin sync stage three
   logic        pin_reg;       // agreed pin level
   logic        mdc_rise;      // divider rise enable
   logic        mdc_fall;      // divider fall enable
   logic        cmd_ok;        // request is legal
   logic        done;          // frame completes now
   logic        en_next;       // enable after this cycle
   logic        drive_slot;    // master owns the line next slot

   // ==========================================================
   // enable gating: zero divider or missing management refuses
   assign en_next = mdio_en_i && (clk_div_i != DIV_RESET)
                    && MGMT_PRESENT;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         en_reg    <= 1'b0;
         mdio_on_o <= 1'b0;
      end else begin
         en_reg    <= en_next;
         mdio_on_o <= en_next;
      end
   end

   // divider setting checked against the mdc ceiling
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         div_ok_o <= 1'b0;
      end else begin
         div_ok_o <= (32'(clk_div_i) >= MDC_MIN_DIV);
      end
   end

   // ==========================================================
   // management clock, derived from the host clock
   mdio_clk_div u_div (
      .clk_i  (clk_i),
      .srst_i (srst_i),
      .run_i  (en_reg && state_reg != ST_IDLE),
      .div_i  (clk_div_i),
      .mdc_o  (mdc_o),
      .rise_o (mdc_rise),
      .fall_o (mdc_fall)
   );

   // ==========================================================
   // pin input synchroniser; level moves when stages 2 and 3 agree
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         sync1_reg <= 1'b1;
         sync2_reg <= 1'b1;
         sync3_reg <= 1'b1;
         pin_reg   <= 1'b1;
      end else begin
         sync1_reg <= mdio_i;
         sync2_reg <= sync1_reg;
         sync3_reg <= sync2_reg;
         if (sync2_reg == sync3_reg) begin
            pin_reg <= sync3_reg;
         end
      end
   end

   // ==========================================================
   // request check: only two opcodes, idle and enabled
   assign cmd_ok = en_reg && (state_reg == ST_IDLE)
                   && (cmd_i.op == OP_WRITE
                       || cmd_i.op == OP_READ);

   // final slot sampled, frame is over at the next fall
   assign done = (state_reg == ST_SHIFT) && mdc_fall
                 && (bit_reg == LAST_BIT);

   // read frames release the line from turnaround on
   assign drive_slot = !is_read_reg || (bit_reg < TA_BIT - 6'h01);

   // refused requests flag a one-cycle error
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         err_o <= 1'b0;
      end else begin
         err_o <= initiate_i && !cmd_ok;
      end
   end

   // ==========================================================
   // frame sequencer; only this master starts a transaction
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_reg   <= ST_IDLE;
         is_read_reg <= 1'b0;
         shift_reg   <= '0;
         bit_reg     <= '0;
      end else begin
         case (state_reg)
            ST_IDLE: begin
               if (initiate_i && cmd_ok) begin
                  state_reg   <= ST_WAIT;
                  is_read_reg <= (cmd_i.op == OP_READ);
                  // preamble, start, op, addresses, ta, data
                  shift_reg   <= {PREAMBLE, ST_CODE, cmd_i.op,
                                  cmd_i.phyad, cmd_i.regad,
                                  TA_WRITE, cmd_i.wdata};
                  bit_reg     <= '0;
               end
            end
            ST_WAIT: begin
               // first falling edge puts slot zero on the line
               if (mdc_fall) begin
                  state_reg <= ST_SHIFT;
                  shift_reg <= {shift_reg[62:0], 1'b0};
               end
            end
            ST_SHIFT: begin
               // next slot launched on every falling edge but the one that ends the frame
               if (done) begin
                  state_reg <= ST_IDLE;
               end else if (mdc_fall) begin
                  bit_reg   <= bit_reg + 6'h01;
                  shift_reg <= {shift_reg[62:0], 1'b0};
               end
            end
            default: begin
               state_reg <= ST_IDLE;
            end
         endcase
         // a disabled interface drops any frame in flight
         if (!en_reg) begin
            state_reg <= ST_IDLE;
         end
      end
   end

   // ==========================================================
   // pin driver: data and enable follow the slot on the line
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mdio_o    <= 1'b1;
         mdio_oe_o <= 1'b0;
      end else if (state_reg == ST_IDLE || done) begin
         mdio_o    <= 1'b1;
         mdio_oe_o <= 1'b0;
      end else if (state_reg == ST_WAIT && mdc_fall) begin
         mdio_o    <= shift_reg[63];
         mdio_oe_o <= 1'b1;
      end else if (state_reg == ST_SHIFT && mdc_fall) begin
         mdio_o    <= shift_reg[63];
         mdio_oe_o <= drive_slot;
      end
   end

   // ==========================================================
   // read capture on rising edges across the data slots
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rx_reg <= '0;
      end else if (state_reg == ST_SHIFT && mdc_rise
                   && is_read_reg && bit_reg >= DATA_BIT) begin
         rx_reg <= {rx_reg[14:0], pin_reg};
      end
   end

   // ==========================================================
   // ready: cleared by a taken initiate, set once frame ends
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ready_reg <= 1'b1;
      end else if (initiate_i && cmd_ok) begin
         ready_reg <= 1'b0;
      end else if (done || (state_reg != ST_IDLE && !en_reg)) begin
         ready_reg <= 1'b1;
      end
   end

   // same ready shown beside control and read data
   assign ctrl_ready_o = ready_reg;
   assign data_ready_o = ready_reg;

   // read data lands in the same cycle that ready returns
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rd_data_o <= RDATA_RESET;
      end else if (done && is_read_reg) begin
         rd_data_o <= rx_reg;
      end
   end

   // completion interrupt; a new completion beats the ack
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         irq_o <= 1'b0;
      end else if (done) begin
         irq_o <= 1'b1;
      end else if (irq_ack_i) begin
         irq_o <= 1'b0;
      end
   end

   // ==========================================================
   // receive settings: applied between frames, reset at once
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         rx_cfg_o <= CFG_RESET;
         rx_rst_o <= 1'b0;
      end else begin
         rx_rst_o <= rx_cfg_i.soft_rst;
         if (!rx_busy_i) begin
            rx_cfg_o <= rx_cfg_i;
         end
      end
   end

   // transmit settings: applied between frames, reset at once
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         tx_cfg_o <= CFG_RESET;
         tx_rst_o <= 1'b0;
      end else begin
         tx_rst_o <= tx_cfg_i.soft_rst;
         if (!tx_busy_i) begin
            tx_cfg_o <= tx_cfg_i;
         end
      end
   end

   // ==========================================================
   // reduced address filter uses the applied receive address
   dest_addr_filter u_filt (
      .clk_i        (clk_i),
      .srst_i       (srst_i || rx_rst_o),
      .da_valid_i   (da_valid_i),
      .da_i         (da_i),
      .pause_addr_i (rx_cfg_o.pause_addr),
      .pause_ok_i   (pause_ok_i),
      .filt_o       (filt_o)
   );

endmodule // mdio_management_controller

// ==== test/mdio_mgmt_monitor.sv ====
// concurrent checks on the management controller ports
module mdio_mgmt_monitor (
   input  wire logic                     clk_i,        // host clock
   input  wire logic                     srst_i,       // sync reset
   input  wire logic [5:0]               clk_div_i,    // divider field
   input  wire logic                     initiate_i,   // start pulse
   input  wire mdio_mgmt_pkg::mdio_cmd_t cmd_i,        // frame request
   input  wire logic                     da_valid_i,   // address valid
   input  wire logic                     pause_ok_i,   // pause criteria
   input  wire logic                     tx_busy_i,    // tx in frame
   input  wire mdio_mgmt_pkg::cfg_vec_t  tx_cfg_i,     // tx settings
   input  wire logic                     mdc_o,        // mgmt clock
   input  wire logic                     mdio_o,       // data out
   input  wire logic                     mdio_oe_o,    // data drive
   input  wire logic                     mdio_on_o,    // enabled
   input  wire logic                     ctrl_ready_o, // ready
   input  wire logic                     irq_o,        // completion
   input  wire logic                     err_o,        // refused start
   input  wire logic                     div_ok_o,     // mdc in limit
   input  wire mdio_mgmt_pkg::cfg_vec_t  tx_cfg_o,     // applied tx
   input  wire logic                     rx_rst_o,     // rx soft reset
   input  wire mdio_mgmt_pkg::filt_t     filt_o        // filter result
);
   timeunit 1ns;
   timeprecision 1ps;
   import mdio_mgmt_pkg::*;

   // ==========================================================
   // helper logic
   logic       start_ok; // start that must be taken
   logic [6:0] hold_q;   // cycles the mdc level has stood
   assign start_ok = initiate_i && mdio_on_o && ctrl_ready_o &&
                     (cmd_i.op == OP_WRITE || cmd_i.op == OP_READ);
   // cycles since mdc last changed
   always_ff @(posedge clk_i) begin
      if (srst_i || $changed(mdc_o)) begin
         hold_q <= 7'h00;
      end else begin
         hold_q <= hold_q + 7'h01;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);

   ready_drop_a: assert property (
      start_ok |=> !ctrl_ready_o && !err_o)
      else $error("ready high after start");
   refuse_err_a: assert property (
      initiate_i && !start_ok |=> err_o)
      else $error("no error on refusal");
   err_cause_a: assert property (
      err_o |-> $past(initiate_i) && !$past(start_ok))
      else $error("error without refusal");
   div_zero_a: assert property (
      clk_div_i == 6'h00 |=> !mdio_on_o)
      else $error("enabled at divider zero");
   div_limit_a: assert property (
      1'b1 |=> div_ok_o == ($past(clk_div_i) >= 6'h27))
      else $error("mdc limit flag wrong");
   mdc_half_a: assert property (
      $fell(mdc_o) |-> hold_q == {1'b0, clk_div_i})
      else $error("mdc high phase length");
   done_irq_a: assert property (
      $rose(ctrl_ready_o) && mdio_on_o |-> irq_o)
      else $error("done without irq");
   slot_edge_a: assert property (
      mdio_oe_o && $past(mdio_oe_o) && $changed(mdio_o) |->
         $past(mdc_o, 2) && !$past(mdc_o))
      else $error("data moved off mdc fall");
   cfg_hold_a: assert property (
      tx_busy_i |=> tx_cfg_o == $past(tx_cfg_o))
      else $error("tx cfg changed in frame");
   cfg_take_a: assert property (
      !tx_busy_i |=> tx_cfg_o == $past(tx_cfg_i))
      else $error("tx cfg not taken in gap");
   pause_rule_a: assert property (
      da_valid_i && !rx_rst_o |=> filt_o.pause ==
         ((filt_o.ucast || filt_o.pmcast) && $past(pause_ok_i)))
      else $error("pause decision wrong");

   cover property (start_ok && cmd_i.op == OP_WRITE);
   cover property (start_ok && cmd_i.op == OP_READ);
   cover property (err_o);
   cover property (da_valid_i && pause_ok_i);
endmodule // mdio_mgmt_monitor

// ==== test/mdio_phy_model.sv ====
// behavioural phy answering management frames on the shared line
module mdio_phy_model #(
   parameter logic [4:0] PHY_ADDR = 5'h01 // own physical address
) (
   input  wire logic        mdc_i,  // management clock
   input  wire logic        mdio_i, // resolved data line
   input  wire logic        moe_i,  // master drives the line
   output logic             drv_o,  // model drives the line
   output logic             dout_o, // model line value
   output logic [35:0]      hdr_o   // preamble, start and opcode seen
);
   timeunit 1ns;
   timeprecision 1ps;
   import mdio_mgmt_pkg::*;
   logic [15:0] regs [32]; // register file
   logic [63:0] sr;        // bits seen this frame
   logic [11:0] adr_q;     // op, phy and register address
   logic        act;       // inside a frame
   int          slot;      // slot sampled at this rise
   initial begin
      act = 1'b0;
      drv_o = 1'b0;
      dout_o = 1'b1;
      hdr_o = '0;
      sr = '0;
      adr_q = '0;
      slot = 0;
   end
   // a frame begins when the master first drives the line
   always @(posedge moe_i) begin
      act = 1'b1;
      slot = 0;
   end
   // sample on each rise, launch read bits just after it
   always @(posedge mdc_i) begin
      if (act) begin
         sr = {sr[62:0], mdio_i};
         if (slot == 35) hdr_o = sr[35:0];
         if (slot == 45) adr_q = sr[11:0];
         if (slot >= 46 && slot < 63 && adr_q[11:10] == OP_READ &&
             adr_q[9:5] == PHY_ADDR) begin
            drv_o = 1'b1;
            dout_o = (slot == 46) ? 1'b0 : regs[adr_q[4:0]][62 - slot];
         end else begin
            drv_o = 1'b0;
         end
         if (slot == 63) begin
            act = 1'b0;
            if (adr_q[11:10] == OP_WRITE && adr_q[9:5] == PHY_ADDR)
               regs[adr_q[4:0]] = sr[15:0];
         end
         slot++;
      end
   end
endmodule // mdio_phy_model

// ==== test/testbench.sv ====
// self-checking bench: controller, phy model and line resolution
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import mdio_mgmt_pkg::*;
   localparam logic [47:0] UADDR = 48'h02ABCDEF0123; // own address
   logic        clk_i, srst_i, mdio_en_i, initiate_i, irq_ack_i;
   logic        rx_busy_i, tx_busy_i, da_valid_i, pause_ok_i;
   logic [5:0]  clk_div_i;
   logic [47:0] da_i;
   mdio_cmd_t   cmd_i;
   cfg_vec_t    rx_cfg_i, tx_cfg_i, rx_cfg_o, tx_cfg_o;
   filt_t       filt_o;
   logic        mdc_o, mdio_o, mdio_oe_o, mdio_on_o, ctrl_ready_o;
   logic        data_ready_o, irq_o, err_o, div_ok_o, rx_rst_o, tx_rst_o;
   logic        phy_drv, phy_dout;
   logic [15:0] rd_data_o;
   logic [35:0] phy_hdr;
   wire logic   mdio_w;
   int          miscompares, n_compared;
   logic [4:0]  ras [2] = '{5'h05, 5'h1F};
   logic [15:0] wds [2] = '{16'hA5C3, 16'h8001};
   logic [47:0] das [4] = '{BCAST_ADDR, PAUSE_MCAST, UADDR, UADDR};
   logic [3:0]  oks = 4'hB; // pause criteria per entry

   // pulled-up shared line
   assign mdio_w = mdio_oe_o ? mdio_o : (phy_drv ? phy_dout : 1'b1);

   mdio_management_controller dut_u (.*, .mdio_i(mdio_w));
   mdio_phy_model phy_u (.mdc_i(mdc_o), .mdio_i(mdio_w), .moe_i(mdio_oe_o),
      .drv_o(phy_drv), .dout_o(phy_dout), .hdr_o(phy_hdr));

   // 200 MHz clock
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end

   // ==========================================================
   // tasks
   task automatic chk(input string nm, input logic [64:0] exp,
                      input logic [64:0] got);
      n_compared++;
      if (got !== exp) begin
         miscompares++;
         $display("unexpected %s: expected %h seen %h", nm, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, miscompares);
      if (miscompares == 0 && n_compared > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask
   // one-cycle start request
   task automatic start(input logic [1:0] op, input logic [4:0] pa,
                        input logic [4:0] ra, input logic [15:0] wd);
      @(posedge clk_i);
      initiate_i <= 1'b1;
      cmd_i <= '{op, pa, ra, wd};
      @(posedge clk_i);
      initiate_i <= 1'b0;
      #1 chk("ready low", 1'b0, ctrl_ready_o);
   endtask
   // refused start
   task automatic refuse(input logic [1:0] op);
      @(posedge clk_i);
      initiate_i <= 1'b1;
      cmd_i.op <= op;
      @(posedge clk_i);
      initiate_i <= 1'b0;
      #1 chk("refused start", 1'b1, err_o);
   endtask
   // bounded wait for ready, then done checks
   task automatic finish(input logic [1:0] op);
      int k = 0;
      while (ctrl_ready_o !== 1'b1 && k < 3000) begin
         @(posedge clk_i);
         #1 k++;
      end
      if (k >= 3000) begin
         miscompares++;
         $display("unexpected hang: expected ready 1 seen %b", ctrl_ready_o);
         stop_test();
      end
      chk("frame length", 1'b1, k >= 380 && k <= 400);
      chk("irq at done", 1'b1, irq_o);
      chk("data ready", 1'b1, data_ready_o);
      chk("frame head", {PREAMBLE, ST_CODE, op}, phy_hdr);
      @(posedge clk_i);
      irq_ack_i <= 1'b1;
      @(posedge clk_i);
      irq_ack_i <= 1'b0;
      #1 chk("irq after ack", 1'b0, irq_o);
   endtask

   // ==========================================================
   // main sequence
   initial begin
      int    i;
      filt_t exp_f;
      {srst_i, mdio_en_i, initiate_i, irq_ack_i} = 4'hC;
      {rx_busy_i, tx_busy_i, da_valid_i, pause_ok_i} = 4'h0;
      clk_div_i = 6'h00;
      da_i = '0;
      cmd_i = '0;
      rx_cfg_i = CFG_RESET;
      tx_cfg_i = CFG_RESET;
      miscompares = 0;
      n_compared = 0;
      repeat (12) @(posedge clk_i);
      srst_i <= 1'b0;
      repeat (3) @(posedge clk_i);
      #1 chk("on at div 0", 1'b0, mdio_on_o);
      refuse(OP_READ);
      for (i = 38; i < 41; i++) begin
         @(posedge clk_i);
         clk_div_i <= (i == 40) ? 6'h02 : 6'(i);
         repeat (2) @(posedge clk_i);
         #1 chk("div ok", i == 39, div_ok_o);
      end
      chk("enabled", 1'b1, mdio_on_o);
      refuse(2'h0);
      refuse(2'h3);
      for (i = 0; i < 2; i++) begin
         start(OP_WRITE, 5'h01, ras[i], wds[i]);
         if (i == 0) refuse(OP_READ);
         finish(OP_WRITE);
         chk("phy register", wds[i], phy_u.regs[ras[i]]);
         start(OP_READ, 5'h01, ras[i], 16'h0000);
         finish(OP_READ);
         chk("read data", wds[i], rd_data_o);
      end
      start(OP_READ, 5'h02, 5'h05, 16'h0000);
      finish(OP_READ);
      chk("absent phy", 16'hFFFF, rd_data_o);
      @(posedge clk_i);
      rx_busy_i <= 1'b1;
      tx_busy_i <= 1'b1;
      @(posedge clk_i);
      rx_cfg_i <= '{UADDR, 16'h5A0F, 1'b1};
      tx_cfg_i <= '{UADDR, 16'hC3A5, 1'b1};
      repeat (2) @(posedge clk_i);
      #1 chk("rx cfg in frame", CFG_RESET, rx_cfg_o);
      chk("tx cfg in frame", CFG_RESET, tx_cfg_o);
      chk("soft resets", 2'h3, {rx_rst_o, tx_rst_o});
      @(posedge clk_i);
      {rx_busy_i, tx_busy_i} <= 2'h0;
      rx_cfg_i.soft_rst <= 1'b0;
      tx_cfg_i.soft_rst <= 1'b0;
      repeat (2) @(posedge clk_i);
      #1 chk("rx cfg in gap", rx_cfg_i, rx_cfg_o);
      chk("tx cfg in gap", tx_cfg_i, tx_cfg_o);
      for (i = 0; i < 4; i++) begin
         @(posedge clk_i);
         da_valid_i <= 1'b1;
         da_i <= das[i];
         pause_ok_i <= oks[i];
         @(posedge clk_i);
         da_valid_i <= 1'b0;
         exp_f.bcast = (das[i] == BCAST_ADDR);
         exp_f.ucast = (das[i] == UADDR);
         exp_f.pmcast = (das[i] == PAUSE_MCAST);
         exp_f.pause = (exp_f.ucast | exp_f.pmcast) & oks[i];
         #1 chk("filter result", exp_f, filt_o);
      end
      stop_test();
   end
endmodule // testbench

bind mdio_management_controller mdio_mgmt_monitor mon_u (.*);
